// >>> verilog/bcd_regs.svh
// Behaviour
// - Three source channels A, B, C and destination D, each with own registers.
// - One shared dimensions register sets the rectangle for all four channels.
// - Pointer high word sits below low word; one long write loads both.
// - Pointers hold byte addresses; bit zero is ignored, transfers are words.
// - With 512 KB of memory the top 13 pointer bits are ignored.
// - Four enable bits in control register zero switch channels individually.
// - Disabled channel makes no memory cycles; disabled source supplies its constant.
// - Source data registers are processor writable as preloaded constants.
// - Data moves one word at a time, only when the bus is granted.
// - On completion a done flag is set and an interrupt is raised.
// - Low six dimension bits give width 1 to 64 words; zero means 64.
// - Upper ten dimension bits give rows 1 to 1024; zero means 1024.
// - Each enabled channel pointer advances two bytes after every word access.
// - At row end each channel adds its own signed 16-bit skip value.
// - Skip is in bytes, bit zero ignored, sign extended to pointer width.
// - Software programs other registers first; writing dimensions starts the operation.
`ifndef BCD_REGS_SVH
`define BCD_REGS_SVH

// ==========================================================
// Register indices (one 16-bit register per index)
`define BCD_CTRL0 5'h00
`define BCD_DIMS 5'h01
`define BCD_CH_BASE 5'h04
`define BCD_CH_STRIDE 5'h04
`define BCD_FLD_PTR_HI 5'h00
`define BCD_FLD_PTR_LO 5'h01
`define BCD_FLD_SKIP 5'h02
`define BCD_FLD_CONST 5'h03

// ==========================================================
// Field positions
`define BCD_EN_A 11
`define BCD_EN_B 10
`define BCD_EN_C 9
`define BCD_EN_D 8
`define BCD_WIDTH_LSB 0
`define BCD_HEIGHT_LSB 6
`define BCD_WIDTH_MAX 7'h40
`define BCD_HEIGHT_MAX 11'h400

// ==========================================================
// Reset values
`define BCD_RST_WORD 16'h0000
`define BCD_RST_EN 4'h0

`endif

// >>> verilog/bcd_pkg.sv
`default_nettype none
// ==========================================================
// Types shared by the engine
package bcd_pkg;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_FETCH = 5'h02,
    S_PUSH = 5'h04,
    S_RES = 5'h08,
    S_WRITE = 5'h10
  } bcd_state_type;
endpackage : bcd_pkg
`default_nettype wire

// >>> verilog/bcd_dma_addr.sv
`include "bcd_regs.svh"
`default_nettype none
module bcd_dma_addr #(
  parameter int PTR_W = 19
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_long,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic mem_req,
  output logic mem_we,
  output logic [PTR_W-1:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_grant,
  input wire logic [15:0] mem_rdata,
  output logic opnd_valid,
  input wire logic opnd_ready,
  output logic [47:0] opnd_data,
  input wire logic res_valid,
  output logic res_ready,
  input wire logic [15:0] res_data,
  output logic busy,
  output logic done_flag,
  output logic done_irq
);

  // ==========================================================
  // Elaboration check
  if (PTR_W < 17 || PTR_W > 32) begin : g_bad_width
    $error("PTR_W must lie between 17 and 32");
  end

  // ==========================================================
  // Helpers
  function automatic logic [4:0] ch_reg(input int ch, input logic [4:0] fld);
    ch_reg = 5'(`BCD_CH_BASE + ch * `BCD_CH_STRIDE + fld);
  endfunction

  // Long write: high half goes to the lower index
  function automatic logic wr_hit(input logic [4:0] idx);
    wr_hit = reg_wr && !busy && (reg_addr == idx || (reg_long && 5'(reg_addr + 5'h01) == idx));
  endfunction

  function automatic logic [15:0] wr_val(input logic [4:0] idx);
    wr_val = (reg_long && reg_addr == idx) ? reg_wdata[31:16] : reg_wdata[15:0];
  endfunction

  // First enabled source at or above from; 3 means none left
  function automatic logic [1:0] next_src(input logic [1:0] from, input logic [2:0] en);
    next_src = 2'h3;
    for (int k = 2; k >= 0; k--) begin
      if (k >= int'(from) && en[k]) begin
        next_src = 2'(k);
      end
    end
  endfunction

  // ==========================================================
  // State
  bcd_pkg::bcd_state_type state_q, state_d;
  logic [1:0] chan_q, chan_d;
  logic [3:0] en_q, en_d;
  logic [PTR_W-2:0] ptr_q [4];
  logic [PTR_W-2:0] ptr_d [4];
  logic [15:0] skip_q [4];
  logic [15:0] skip_d [4];
  logic [15:0] const_q [3];
  logic [15:0] const_d [3];
  logic [6:0] width_q, width_d, wcnt_q, wcnt_d;
  logic [10:0] rcnt_q, rcnt_d;
  logic [15:0] wdata_q, wdata_d;
  logic busy_q, done_q, irq_q, res_ready_q;
  logic mem_req_q, mem_we_q;
  logic [PTR_W-1:0] mem_addr_q;
  logic out_v_q, out_v_d, skid_v_q, skid_v_d;
  logic [47:0] out_q, out_d, skid_q, skid_d;
  logic word_end, finish, push;

  // ==========================================================
  // Decode
  wire logic start = wr_hit(`BCD_DIMS);
  wire logic [15:0] dims_val = wr_val(`BCD_DIMS);
  wire logic [5:0] w_fld = dims_val[`BCD_WIDTH_LSB +: 6];
  wire logic [9:0] h_fld = dims_val[`BCD_HEIGHT_LSB +: 10];
  wire logic [6:0] width_dec = (w_fld == 6'h00) ? `BCD_WIDTH_MAX : {1'b0, w_fld};
  wire logic [10:0] height_dec = (h_fld == 10'h000) ? `BCD_HEIGHT_MAX : {1'b0, h_fld};
  wire logic [15:0] ctrl_val = wr_val(`BCD_CTRL0);
  wire logic [1:0] first_src = next_src(2'h0, en_d[2:0]);
  wire logic eol = (wcnt_q == 7'h01);
  wire logic buf_in_ready = !skid_v_q; // Stalls the engine when the buffer is full
  wire logic pop = out_v_q && opnd_ready;
  wire logic grant_fetch = (state_q == bcd_pkg::S_FETCH) && mem_grant;
  wire logic grant_write = (state_q == bcd_pkg::S_WRITE) && mem_grant;

  // Channel enables from control register zero
  always_comb begin
    en_d = en_q;
    if (wr_hit(`BCD_CTRL0)) begin
      en_d = {ctrl_val[`BCD_EN_D], ctrl_val[`BCD_EN_C], ctrl_val[`BCD_EN_B], ctrl_val[`BCD_EN_A]};
    end
  end

  // Per-channel pointer, skip and constant registers
  always_comb begin
    logic [15:0] hi_v;
    logic [15:0] lo_v;
    hi_v = 16'h0000;
    lo_v = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      ptr_d[i] = ptr_q[i];
      hi_v = wr_val(ch_reg(i, `BCD_FLD_PTR_HI));
      lo_v = wr_val(ch_reg(i, `BCD_FLD_PTR_LO));
      skip_d[i] = skip_q[i];
      // Upper bits beyond the memory size are dropped here
      if (wr_hit(ch_reg(i, `BCD_FLD_PTR_HI))) begin
        ptr_d[i][PTR_W-2:15] = hi_v[PTR_W-17:0];
      end
      if (wr_hit(ch_reg(i, `BCD_FLD_PTR_LO))) begin
        ptr_d[i][14:0] = lo_v[15:1];
      end
      if (wr_hit(ch_reg(i, `BCD_FLD_SKIP))) begin
        skip_d[i] = wr_val(ch_reg(i, `BCD_FLD_SKIP));
      end
      // Advance one word, plus the skip at row end
      if ((grant_fetch && chan_q == 2'(i)) || (grant_write && i == 3)) begin
        ptr_d[i] = ptr_q[i] + (PTR_W-1)'(1)
          + (eol ? {{(PTR_W-16){skip_q[i][15]}}, skip_q[i][15:1]} : (PTR_W-1)'(0));
      end
    end
    for (int i = 0; i < 3; i++) begin
      const_d[i] = const_q[i];
      if (wr_hit(ch_reg(i, `BCD_FLD_CONST))) begin
        const_d[i] = wr_val(ch_reg(i, `BCD_FLD_CONST));
      end
      if (grant_fetch && chan_q == 2'(i)) begin
        const_d[i] = mem_rdata;
      end
    end
  end

  // Sequencer: sources, operand push, result, destination write
  always_comb begin
    state_d = state_q;
    chan_d = chan_q;
    wcnt_d = wcnt_q;
    rcnt_d = rcnt_q;
    width_d = width_q;
    wdata_d = wdata_q;
    word_end = 1'b0;
    finish = 1'b0;
    push = 1'b0;
    case (state_q)
      bcd_pkg::S_IDLE: begin
        if (start) begin
          width_d = width_dec;
          wcnt_d = width_dec;
          rcnt_d = height_dec;
          chan_d = first_src;
          state_d = (first_src == 2'h3) ? bcd_pkg::S_PUSH : bcd_pkg::S_FETCH;
        end
      end
      bcd_pkg::S_FETCH: begin
        if (mem_grant) begin
          chan_d = next_src(2'(chan_q + 2'h1), en_q[2:0]);
          if (chan_d == 2'h3) begin
            state_d = bcd_pkg::S_PUSH;
          end
        end
      end
      bcd_pkg::S_PUSH: begin
        if (buf_in_ready) begin
          push = 1'b1;
          if (en_q[3]) begin
            state_d = bcd_pkg::S_RES;
          end else begin
            word_end = 1'b1;
          end
        end
      end
      bcd_pkg::S_RES: begin
        if (res_valid) begin
          wdata_d = res_data;
          chan_d = 2'h3;
          state_d = bcd_pkg::S_WRITE;
        end
      end
      bcd_pkg::S_WRITE: begin
        if (mem_grant) begin
          word_end = 1'b1;
        end
      end
      default: begin
        state_d = bcd_pkg::S_IDLE;
      end
    endcase
    // Word and row counting
    if (word_end) begin
      chan_d = first_src;
      state_d = (first_src == 2'h3) ? bcd_pkg::S_PUSH : bcd_pkg::S_FETCH;
      if (eol) begin
        wcnt_d = width_q;
        if (rcnt_q == 11'h001) begin
          finish = 1'b1;
          state_d = bcd_pkg::S_IDLE;
        end else begin
          rcnt_d = 11'(rcnt_q - 11'h001);
        end
      end else begin
        wcnt_d = 7'(wcnt_q - 7'h01);
      end
    end
  end

  // Two-entry operand buffer: output stage plus skid
  always_comb begin
    out_v_d = out_v_q;
    out_d = out_q;
    skid_v_d = skid_v_q;
    skid_d = skid_q;
    if (pop) begin
      out_v_d = skid_v_q;
      out_d = skid_q;
      skid_v_d = 1'b0;
    end
    if (push) begin
      // Disabled sources contribute their held constant
      if (!out_v_d) begin
        out_v_d = 1'b1;
        out_d = {const_q[0], const_q[1], const_q[2]};
      end else begin
        skid_v_d = 1'b1;
        skid_d = {const_q[0], const_q[1], const_q[2]};
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= bcd_pkg::S_IDLE;
      chan_q <= 2'h0;
      en_q <= `BCD_RST_EN;
      width_q <= `BCD_WIDTH_MAX;
      wcnt_q <= `BCD_WIDTH_MAX;
      rcnt_q <= `BCD_HEIGHT_MAX;
      wdata_q <= `BCD_RST_WORD;
      out_v_q <= 1'b0;
      skid_v_q <= 1'b0;
      out_q <= 48'h000000000000;
      skid_q <= 48'h000000000000;
    end else begin
      state_q <= state_d;
      chan_q <= chan_d;
      en_q <= en_d;
      width_q <= width_d;
      wcnt_q <= wcnt_d;
      rcnt_q <= rcnt_d;
      wdata_q <= wdata_d;
      out_v_q <= out_v_d;
      skid_v_q <= skid_v_d;
      out_q <= out_d;
      skid_q <= skid_d;
    end
  end

  // Channel register file; one set per channel
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 4; i++) begin
      ptr_q[i] <= sys_rst ? (PTR_W-1)'(0) : ptr_d[i];
      skip_q[i] <= sys_rst ? `BCD_RST_WORD : skip_d[i];
    end
    for (int i = 0; i < 3; i++) begin
      const_q[i] <= sys_rst ? `BCD_RST_WORD : const_d[i];
    end
  end

  // Outputs come from their own flops, computed from next state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= PTR_W'(0);
      busy_q <= 1'b0;
      done_q <= 1'b0;
      irq_q <= 1'b0;
      res_ready_q <= 1'b0;
    end else begin
      mem_req_q <= (state_d == bcd_pkg::S_FETCH) || (state_d == bcd_pkg::S_WRITE);
      mem_we_q <= (state_d == bcd_pkg::S_WRITE);
      mem_addr_q <= {ptr_d[chan_d], 1'b0};
      busy_q <= (state_d != bcd_pkg::S_IDLE);
      done_q <= finish | (done_q & ~start);
      irq_q <= finish;
      res_ready_q <= (state_d == bcd_pkg::S_RES);
    end
  end

  assign mem_req = mem_req_q;
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = wdata_q;
  assign opnd_valid = out_v_q;
  assign opnd_data = out_q;
  assign res_ready = res_ready_q;
  assign busy = busy_q;
  assign done_flag = done_q;
  assign done_irq = irq_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_result_taken;
    (state_q == bcd_pkg::S_RES) && res_valid;
  endsequence

  sequence s_write_issued;
    mem_req && mem_we && (mem_addr == {ptr_q[3], 1'b0});
  endsequence

  a_read_enabled_only: assert property (
    mem_req && !mem_we |-> chan_q != 2'h3 && en_q[chan_q])
    else $error("read cycle on a disabled channel");

  a_write_enabled_only: assert property (
    mem_req && mem_we |-> en_q[3])
    else $error("write cycle with destination disabled");

  a_ptr_step_word: assert property (
    grant_fetch && !eol |=> ptr_q[$past(chan_q)] == (PTR_W-1)'($past(ptr_q[chan_q]) + (PTR_W-1)'(1)))
    else $error("pointer did not advance one word");

  a_ptr_row_skip: assert property (
    grant_write && eol |=> ptr_q[3] ==
      (PTR_W-1)'($past(ptr_q[3]) + (PTR_W-1)'(1) + {{(PTR_W-16){skip_q[3][15]}}, skip_q[3][15:1]}))
    else $error("row skip not applied to destination");

  a_const_load: assert property (
    grant_fetch |=> const_q[$past(chan_q)] == $past(mem_rdata))
    else $error("fetched word not held in data register");

  a_result_write: assert property (
    s_result_taken |=> s_write_issued ##0 (mem_wdata == $past(res_data)))
    else $error("result word not written to destination");

  a_start_busy: assert property (
    start |=> busy ##0 !done_flag)
    else $error("dimensions write did not start the engine");

  a_width_zero: assert property (
    start && w_fld == 6'h00 |=> width_q == 7'h40 && wcnt_q == 7'h40)
    else $error("zero width not taken as 64 words");

  a_height_zero: assert property (
    start && h_fld == 10'h000 |=> rcnt_q == 11'h400)
    else $error("zero height not taken as 1024 rows");

  a_done_idle: assert property (
    done_irq |-> done_flag && !busy ##1 !done_irq)
    else $error("completion not a single pulse with idle engine");

  a_addr_even: assert property (
    mem_req |-> mem_addr[0] == 1'b0)
    else $error("odd memory address issued");

  a_buf_hold: assert property (
    opnd_valid && !opnd_ready |=> opnd_valid && $stable(opnd_data))
    else $error("operand lost while stalled");

endmodule : bcd_dma_addr
`default_nettype wire

// >>> test/bcd_mem_model.sv
`default_nettype none
// ==========================================================
// Word memory on the shared bus; grants after wait_n cycles
module bcd_mem_model #(
  parameter int PTR_W = 19
) (
  input wire logic sys_clk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [PTR_W-1:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [3:0] wait_n,
  output logic mem_grant,
  output logic [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem_q [0:1023];
  logic [3:0] cnt_q = 4'h0;
  logic [15:0] word;
  // Slow mode makes the engine hold its request over several cycles
  assign mem_grant = mem_req && (cnt_q >= wait_n);
  assign word = mem_q[mem_addr[10:1]];
  // Outside a granted read the bus shows the inverse, never a stale copy
  assign mem_rdata = (mem_grant && !mem_we) ? word : ~word;
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem_q[i] = 16'(i * 16'h0137) ^ 16'h5A3C;
    end
  end
  // Wait counter and write port
  always @(posedge sys_clk) begin
    cnt_q <= (mem_req && !mem_grant) ? cnt_q + 4'h1 : 4'h0;
    if (mem_grant && mem_we) begin
      mem_q[mem_addr[10:1]] <= mem_wdata;
    end
  end
endmodule // bcd_mem_model
`default_nettype wire

// >>> test/block_copy_dma_addressing_bench.sv
`include "bcd_regs.svh"
`default_nettype none
// ==========================================================
// Table of block copies, then reset and refusal cases
module block_copy_dma_addressing_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PW = 19;
  typedef struct {
    logic [3:0] en;
    logic [15:0] dims;
    logic [3:0] wt;
    logic st;
    logic [31:0] ptr [4];
    logic [15:0] skip [4];
    logic [15:0] cst [3];
  } bcd_row_type;
  logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_long = 1'b0;
  logic mem_req, mem_we, mem_grant, opnd_valid, res_ready, busy, done_flag, done_irq;
  logic opnd_ready = 1'b1, res_valid = 1'b0, st_q = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [PW-1:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [15:0] res_data = 16'h0;
  logic [47:0] opnd_data;
  logic [3:0] wait_n = 4'h0, tick = 4'h0;
  logic [35:0] expq [$];
  logic [47:0] expo [$], opq [$];
  int err_total = 0, num_checks = 0, irq_n = 0;
  bcd_row_type rows [6];
  bcd_row_type zr;

  always #4 sys_clk = ~sys_clk;

  bcd_dma_addr #(.PTR_W(PW)) i_bcd_dma_addr (.sys_clk, .sys_rst, .reg_wr, .reg_long, .reg_addr, .reg_wdata,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_grant, .mem_rdata, .opnd_valid, .opnd_ready, .opnd_data,
    .res_valid, .res_ready, .res_data, .busy, .done_flag, .done_irq);
  bcd_mem_model #(.PTR_W(PW)) i_bcd_mem_model (.sys_clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .wait_n,
    .mem_grant, .mem_rdata);

  // ==========================================================
  // Helpers
  task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  // Register writes stay strobed back to back; idle drops the strobe
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic lg);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    reg_long = lg;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic idle();
    reg_wr = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p, input logic [15:0] s, input bit last);
    return p + PW'(2) + (last ? {{(PW-16){s[15]}}, s[15:1], 1'b0} : PW'(0));
  endfunction
  // Reference walk of the rectangle: bus cycles and operand sets in order
  task automatic build(input bcd_row_type r);
    logic [PW-1:0] p [4];
    logic [47:0] op;
    int w, h;
    w = (r.dims[5:0] == 6'h00) ? 64 : int'(r.dims[5:0]);
    h = (r.dims[15:6] == 10'h000) ? 1024 : int'(r.dims[15:6]);
    for (int k = 0; k < 4; k++) p[k] = {r.ptr[k][PW-1:1], 1'b0};
    for (int y = 0; y < h; y++) begin
      for (int x = 0; x < w; x++) begin
        for (int k = 0; k < 3; k++) begin
          op[47-16*k -: 16] = r.cst[k];
          if (r.en[3-k]) begin
            op[47-16*k -: 16] = i_bcd_mem_model.mem_q[p[k][10:1]];
            expq.push_back({1'b0, p[k], 16'h0000});
            p[k] = nxt(p[k], r.skip[k], x == w - 1);
          end
        end
        expo.push_back(op);
        if (r.en[0]) begin
          expq.push_back({1'b1, p[3], op[47:32] ^ op[31:16] ^ op[15:0]});
          p[3] = nxt(p[3], r.skip[3], x == w - 1);
        end
      end
    end
  endtask
  task automatic start(input bcd_row_type r, input bit prog);
    wait_n = r.wt;
    st_q = r.st;
    opq.delete();
    for (int k = 0; k < 4 && prog; k++) begin
      wr(5'(`BCD_CH_BASE + 4 * k), r.ptr[k], 1'b1);
      wr(5'(`BCD_CH_BASE + 4 * k + 2), {16'h0000, r.skip[k]}, 1'b0);
      if (k < 3) wr(5'(`BCD_CH_BASE + 4 * k + 3), {16'h0000, r.cst[k]}, 1'b0);
    end
    wr(`BCD_CTRL0, {20'h00000, r.en, 8'h00}, 1'b0);
    build(r);
    irq_n = 0;
    wr(`BCD_DIMS, {16'h0000, r.dims}, 1'b0);
    idle();
    check({busy, done_flag}, 2'b10, "start");
  endtask
  task automatic finish();
    int n;
    n = 0;
    while ((busy !== 1'b0 || expo.size() > 0) && n < 20000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    @(posedge sys_clk);
    #1;
    check({busy, done_flag, done_irq}, 3'b010, "end state");
    check(48'(irq_n), 48'h1, "done pulse");
    check(48'(expq.size()), 48'h0, "missing cycles");
  endtask
  task automatic print_verdict();
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================
  // Bus watcher and stand-in function unit (result = A ^ B ^ C)
  always @(posedge sys_clk) begin
    if (mem_req === 1'b1 && mem_grant === 1'b1) begin
      check({mem_we, mem_addr, mem_we ? mem_wdata : 16'h0000},
        expq.size() > 0 ? expq.pop_front() : '1, "memory cycle");
    end
    if (opnd_valid === 1'b1 && opnd_ready === 1'b1) begin
      check(opnd_data, expo.size() > 0 ? expo.pop_front() : 'x, "operand");
      opq.push_back(opnd_data);
    end
    if (res_valid === 1'b1 && res_ready === 1'b1) void'(opq.pop_front());
    if (done_irq === 1'b1) irq_n++;
    #1;
    tick = tick + 4'h1;
    // Long stalls fill the two-entry buffer until it refuses
    opnd_ready = !st_q || tick >= 4'hC;
    res_valid = opq.size() > 0;
    res_data = opq.size() > 0 ? (opq[0][47:32] ^ opq[0][31:16] ^ opq[0][15:0]) : ~res_data;
  end

  // ==========================================================
  // Main sequence
  initial begin
    zr = '{4'h1, 16'h0042, 4'h0, 1'b0, '{4{32'h0}}, '{4{16'h0}}, '{3{16'h0}}};
    rows[0] = '{4'h9, 16'h0083, 4'h0, 1'b0, '{32'hFFF8_0101, 32'h0, 32'h0, 32'h0000_0601},
      '{16'h0005, 16'h0, 16'h0, 16'hFFFE}, '{16'h1111, 16'h2222, 16'h3333}};
    rows[1] = '{4'hF, 16'h0082, 4'h2, 1'b1, '{32'h0100, 32'h0180, 32'h01C0, 32'h0700},
      '{16'h0, 16'hFFFD, 16'h0010, 16'h0}, '{3{16'h0}}};
    rows[2] = '{4'h1, 16'h0043, 4'h1, 1'b0, '{32'h0, 32'h0, 32'h0, 32'h0740},
      '{16'h0, 16'h0, 16'h0, 16'h0004}, '{16'h1234, 16'h0F0F, 16'h8001}};
    rows[3] = '{4'hA, 16'h0104, 4'h0, 1'b1, '{32'h0200, 32'h0, 32'h0280, 32'h0},
      '{16'h0002, 16'h0, 16'h0, 16'h0}, '{16'h0, 16'h5555, 16'h0}};
    rows[4] = '{4'h9, 16'h0040, 4'h0, 1'b1, '{32'h0300, 32'h0, 32'h0, 32'h0780},
      '{4{16'h0}}, '{3{16'h0}}};
    rows[5] = '{4'h5, 16'h0001, 4'h0, 1'b0, '{32'h0, 32'h0400, 32'h0, 32'h0500},
      '{16'h0, 16'hFFFE, 16'h0, 16'hFFFE}, '{16'hABCD, 16'h0, 16'h0}};
    repeat (4) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    check({busy, done_flag, done_irq, mem_req, opnd_valid, res_ready}, 6'h00, "reset state");
    // Destination pointer and constants must come out of reset as zero
    start(zr, 1'b0);
    finish();
    for (int i = 0; i < 6; i++) begin
      start(rows[i], 1'b1);
      finish();
    end
    // Writes while busy, unmapped index included, must change nothing
    start(rows[1], 1'b1);
    wr(`BCD_DIMS, 32'h0000_0041, 1'b0);
    wr(5'h1F, 32'h0, 1'b0);
    wr(`BCD_CTRL0, 32'h0, 1'b0);
    idle();
    finish();
    // Reset in mid run aborts and clears the register file
    start(rows[5], 1'b1);
    repeat (20) @(posedge sys_clk);
    #1;
    sys_rst = 1'b1;
    @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    check({busy, done_flag, mem_req, opnd_valid, res_ready}, 5'h00, "mid reset");
    expq.delete();
    expo.delete();
    start(zr, 1'b0);
    finish();
    print_verdict();
  end

  // Watchdog well beyond the expected run of about seven thousand cycles
  initial begin
    #700000;
    err_total++;
    print_verdict();
  end
endmodule // block_copy_dma_addressing_bench
`default_nettype wire
